// ### hdl/tks_scan_top.sv
// Touch key scan counters with register port and interrupt
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "tks_consts.svh"

module tks_scan_top (
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic [`TKS_ADDR_W-1:0]   regAddr,
    input  wire logic [7:0]               regWrData,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    output logic      [7:0]               regRdData_r,
    output logic                          irq_r,
    input  wire logic                     keyOscIn,
    input  wire logic                     refOscIn,
    output logic                          keyOscRun_r,
    output logic                          refOscRun_r,
    output logic      [1:0]               oscRange_r,
    output logic      [3:0]               touchPinSel_r,
    output logic      [7:0]               modCtrlA_r,
    output logic      [9:0]               refCap_r
);
    tks_pkg::tks_state_e state_r;
    tks_pkg::tks_state_e state_nxt;

    logic [7:0]  slotPreload_r;
    logic [7:0]  scanCtrl_r;
    logic [7:0]  modCtrlB_r;
    logic [7:0]  slotCnt_r;
    logic [4:0]  unitDiv_r;
    logic [15:0] freqCnt_r;
    logic [15:0] calCnt_r;
    logic [2:0]  sysPre_r;
    logic        startPrev_r;
    logic [2:0]  irqStat_r;
    logic [2:0]  irqMask_r;
    logic        keyRise;
    logic        refRise;
    logic        scanStart;
    logic        startRise;
    logic        running;
    logic        slotTick;
    logic        calTick;
    logic        slotOvf;
    logic        freqOvf;
    logic        calOvf;
    logic        wrScanCtrl;
    logic        rdStat;
    logic [7:0]  rdMux;

    // Tick when low prescaler bits below the divide code are all ones
    function automatic logic divTick(input logic [1:0] sel, input logic [2:0] pre);
        logic t;
        t = 1'b0;
        case (sel)
            2'h0:    t = 1'b1;
            2'h1:    t = pre[0];
            2'h2:    t = &pre[1:0];
            2'h3:    t = &pre;
            default: t = 1'b1;
        endcase
        return t;
    endfunction : divTick

    tks_osc_sync u_keySync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .oscIn   (keyOscIn),
        .oscRise (keyRise)
    );

    tks_osc_sync u_refSync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .oscIn   (refOscIn),
        .oscRise (refRise)
    );

    assign scanStart  = scanCtrl_r[`TKS_SC_START];
    assign startRise  = scanStart & ~startPrev_r;
    assign running    = (state_r == tks_pkg::TKS_RUN);
    assign wrScanCtrl = regWrite && (regAddr == `TKS_OFF_SCAN_CTRL);
    assign rdStat     = regRead && (regAddr == `TKS_OFF_IRQ_STAT);

    // Slot clock source select
    assign slotTick = modCtrlB_r[`TKS_MB_SLOT_SRC] ? divTick(`TKS_SYS_DIV4_SEL, sysPre_r) : refRise;
    assign calTick  = divTick(scanCtrl_r[1:0], sysPre_r);

    // Overflow at divider and slot counter wrap together
    assign slotOvf = running && slotTick && (unitDiv_r == `TKS_DIV_LAST)
                     && (slotCnt_r == `TKS_SLOT_LAST);
    assign freqOvf = running && keyRise && (freqCnt_r == `TKS_CNT_LAST);
    assign calOvf  = running && calTick && (calCnt_r == `TKS_CNT_LAST);

    // Scan sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tks_pkg::TKS_IDLE: begin
                if (startRise) begin
                    state_nxt = tks_pkg::TKS_RUN;
                end
            end
            tks_pkg::TKS_RUN: begin
                if (!scanStart) begin
                    state_nxt = tks_pkg::TKS_IDLE;
                end else if (slotOvf) begin
                    state_nxt = tks_pkg::TKS_DONE;
                end
            end
            tks_pkg::TKS_DONE: begin
                if (!scanStart) begin
                    state_nxt = tks_pkg::TKS_IDLE;
                end
            end
            default: state_nxt = tks_pkg::TKS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r     <= tks_pkg::TKS_IDLE;
            startPrev_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            startPrev_r <= scanStart;
        end
    end

    // System clock prescaler, aligned to scan start
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sysPre_r <= 3'h0;
        end else if (!running) begin
            sysPre_r <= 3'h0;
        end else begin
            sysPre_r <= sysPre_r + 3'h1;
        end
    end

    // Unit period divider
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            unitDiv_r <= 5'h0;
        end else if (!scanStart) begin
            unitDiv_r <= 5'h0;
        end else if (running && slotTick) begin
            unitDiv_r <= unitDiv_r + 5'h1;
        end
    end

    // Slot counter, loaded at start, kept while idle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            slotCnt_r <= 8'h0;
        end else if (startRise) begin
            slotCnt_r <= slotPreload_r;
        end else if (running && slotTick && (unitDiv_r == `TKS_DIV_LAST)) begin
            slotCnt_r <= slotCnt_r + 8'h1;
        end
    end

    // Capacitance to frequency counter
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            freqCnt_r <= 16'h0;
        end else if (!scanStart) begin
            freqCnt_r <= 16'h0;
        end else if (running && keyRise) begin
            freqCnt_r <= freqCnt_r + 16'h1;
        end
    end

    // Calibration counter
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            calCnt_r <= 16'h0;
        end else if (!scanStart) begin
            calCnt_r <= 16'h0;
        end else if (running && calTick) begin
            calCnt_r <= calCnt_r + 16'h1;
        end
    end

    // Scan control: flags set by hardware, only cleared by software
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scanCtrl_r <= 8'h0;
        end else begin
            if (wrScanCtrl) begin
                scanCtrl_r[`TKS_SC_START] <= regWrData[`TKS_SC_START];
                scanCtrl_r[1:0]           <= regWrData[1:0];
            end
            scanCtrl_r[`TKS_SC_WIN_OV] <= slotOvf | (scanCtrl_r[`TKS_SC_WIN_OV]
                & ~(wrScanCtrl & ~regWrData[`TKS_SC_WIN_OV]));
            scanCtrl_r[`TKS_SC_FREQ_OV] <= freqOvf | (scanCtrl_r[`TKS_SC_FREQ_OV]
                & ~(wrScanCtrl & ~regWrData[`TKS_SC_FREQ_OV]));
            scanCtrl_r[`TKS_SC_CAL_OV] <= calOvf | (scanCtrl_r[`TKS_SC_CAL_OV]
                & ~(wrScanCtrl & ~regWrData[`TKS_SC_CAL_OV]));
            scanCtrl_r[7] <= 1'b0;
            scanCtrl_r[2] <= 1'b0;
        end
    end

    // Plain read-write registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            slotPreload_r <= 8'h0;
            oscRange_r    <= `TKS_OSC_SEL_RESET;
            refCap_r      <= 10'h0;
            modCtrlA_r    <= 8'h0;
            modCtrlB_r    <= 8'h0;
            irqMask_r     <= 3'h0;
        end else if (regWrite) begin
            case (regAddr)
                `TKS_OFF_PRELOAD:    slotPreload_r <= regWrData;
                `TKS_OFF_OSC_SEL:    oscRange_r    <= regWrData[1:0];
                `TKS_OFF_REFCAP_LO:  refCap_r[7:0] <= regWrData;
                `TKS_OFF_REFCAP_HI:  refCap_r[9:8] <= regWrData[1:0];
                `TKS_OFF_MOD_CTRL_A: modCtrlA_r    <= regWrData;
                `TKS_OFF_MOD_CTRL_B: modCtrlB_r    <= regWrData & `TKS_MB_IMPL_MASK;
                `TKS_OFF_IRQ_MASK:   irqMask_r     <= regWrData[2:0];
                default: begin
                end
            endcase
        end
    end

    // Oscillator enables and pin function select
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            keyOscRun_r   <= 1'b0;
            refOscRun_r   <= 1'b0;
            touchPinSel_r <= 4'h0;
        end else begin
            keyOscRun_r   <= (state_nxt == tks_pkg::TKS_RUN) && modCtrlB_r[`TKS_MB_KEY_OSC_EN];
            refOscRun_r   <= (state_nxt == tks_pkg::TKS_RUN) && modCtrlB_r[`TKS_MB_REF_OSC_EN];
            touchPinSel_r <= modCtrlB_r[3:0];
        end
    end

    // Sticky interrupt status, cleared by read; set wins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irqStat_r <= 3'h0;
            irq_r     <= 1'b0;
        end else begin
            irqStat_r[`TKS_IRQ_WIN]  <= slotOvf | (irqStat_r[`TKS_IRQ_WIN] & ~rdStat);
            irqStat_r[`TKS_IRQ_FREQ] <= freqOvf | (irqStat_r[`TKS_IRQ_FREQ] & ~rdStat);
            irqStat_r[`TKS_IRQ_CAL]  <= calOvf | (irqStat_r[`TKS_IRQ_CAL] & ~rdStat);
            irq_r                    <= |(irqStat_r & irqMask_r);
        end
    end

    // Read multiplexer
    always_comb begin
        rdMux = 8'h0;
        case (regAddr)
            `TKS_OFF_PRELOAD:    rdMux = slotPreload_r;
            `TKS_OFF_SCAN_CTRL:  rdMux = scanCtrl_r & `TKS_SC_IMPL_MASK;
            `TKS_OFF_OSC_SEL:    rdMux = {6'h0, oscRange_r};
            `TKS_OFF_CAL_LO:     rdMux = calCnt_r[7:0];
            `TKS_OFF_CAL_HI:     rdMux = calCnt_r[15:8];
            `TKS_OFF_FREQ_LO:    rdMux = freqCnt_r[7:0];
            `TKS_OFF_FREQ_HI:    rdMux = freqCnt_r[15:8];
            `TKS_OFF_REFCAP_LO:  rdMux = refCap_r[7:0];
            `TKS_OFF_REFCAP_HI:  rdMux = {6'h0, refCap_r[9:8]};
            `TKS_OFF_MOD_CTRL_A: rdMux = modCtrlA_r;
            `TKS_OFF_MOD_CTRL_B: rdMux = modCtrlB_r;
            `TKS_OFF_IRQ_STAT:   rdMux = {5'h0, irqStat_r};
            `TKS_OFF_IRQ_MASK:   rdMux = {5'h0, irqMask_r};
            default:             rdMux = 8'h0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            regRdData_r <= 8'h0;
        end else if (regRead) begin
            regRdData_r <= rdMux;
        end else begin
            regRdData_r <= 8'h0;
        end
    end
endmodule : tks_scan_top

// ### hdl/tks_consts.svh
// Offsets, field positions, reset values and counts of the touch key scan block
`ifndef TKS_CONSTS_SVH
`define TKS_CONSTS_SVH

`define TKS_ADDR_W          4
`define TKS_OFF_PRELOAD     4'h0
`define TKS_OFF_SCAN_CTRL   4'h1
`define TKS_OFF_OSC_SEL     4'h2
`define TKS_OFF_CAL_LO      4'h3
`define TKS_OFF_CAL_HI      4'h4
`define TKS_OFF_FREQ_LO     4'h5
`define TKS_OFF_FREQ_HI     4'h6
`define TKS_OFF_REFCAP_LO   4'h7
`define TKS_OFF_REFCAP_HI   4'h8
`define TKS_OFF_MOD_CTRL_A  4'h9
`define TKS_OFF_MOD_CTRL_B  4'hA
`define TKS_OFF_IRQ_STAT    4'hB
`define TKS_OFF_IRQ_MASK    4'hC

`define TKS_SC_WIN_OV       6
`define TKS_SC_START        5
`define TKS_SC_FREQ_OV      4
`define TKS_SC_CAL_OV       3
`define TKS_MB_SLOT_SRC     7
`define TKS_MB_REF_OSC_EN   5
`define TKS_MB_KEY_OSC_EN   4
`define TKS_MB_IMPL_MASK    8'hBF
`define TKS_SC_IMPL_MASK    8'h7B
`define TKS_REFCAP_HI_MASK  8'h03

`define TKS_IRQ_WIN         0
`define TKS_IRQ_FREQ        1
`define TKS_IRQ_CAL         2

`define TKS_OSC_SEL_RESET   2'h3
`define TKS_DIV_LAST        5'h1F
`define TKS_SLOT_LAST       8'hFF
`define TKS_CNT_LAST        16'hFFFF
`define TKS_SYS_DIV4_SEL    2'h2

`endif

// ### hdl/tks_pkg.sv
// Types of the touch key scan block
package tks_pkg;
    typedef enum logic [1:0] {
        TKS_IDLE = 2'b00,
        TKS_RUN  = 2'b01,
        TKS_DONE = 2'b10
    } tks_state_e;
endpackage : tks_pkg

// ### hdl/tks_osc_sync.sv
// Two-stage synchroniser with rising edge pulse for an oscillator input
module tks_osc_sync (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic oscIn,
    output logic      oscRise
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_r  <= 1'b0;
            sync_r  <= 1'b0;
            prev_r  <= 1'b0;
            oscRise <= 1'b0;
        end else begin
            meta_r  <= oscIn;
            sync_r  <= meta_r;
            prev_r  <= sync_r;
            oscRise <= sync_r & ~prev_r;
        end
    end
endmodule : tks_osc_sync

// ### test/tks_osc_model.sv
// Sense and reference oscillator model of the touch pads
module tks_osc_model (
    input  wire logic keyRun,
    input  wire logic refRun,
    output logic      keyOsc,
    output logic      refOsc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        keyOsc = 1'b0;
        refOsc = 1'b0;
    end
    // Stands still while not enabled
    always #45 if (keyRun) keyOsc = ~keyOsc;
    always #43 if (refRun) refOsc = ~refOsc;
endmodule : tks_osc_model

// ### test/tks_scan_checker.sv
// Port checks of the touch key scan block
`include "tks_consts.svh"
module tks_scan_checker (
    input wire logic                   ref_clk,
    input wire logic                   reset,
    input wire logic [`TKS_ADDR_W-1:0] regAddr,
    input wire logic [7:0]             regWrData,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [7:0]             regRdData_r,
    input wire logic                   keyOscRun_r,
    input wire logic                   refOscRun_r,
    input wire logic [1:0]             oscRange_r,
    input wire logic [7:0]             modCtrlA_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    rd_idle_zero_a: assert property (!regRead |=> regRdData_r == 8'h00)
        else $error("read data not zero when idle");
    unmapped_rd_a: assert property (regRead && regAddr > `TKS_OFF_IRQ_MASK |=> regRdData_r == 8'h00)
        else $error("unmapped read not zero");
    oscsel_rd_a: assert property (regRead && regAddr == `TKS_OFF_OSC_SEL |=> regRdData_r[7:2] == 6'h00)
        else $error("osc select spare bits set");
    ctrl_rd_a: assert property (regRead && regAddr == `TKS_OFF_SCAN_CTRL |=>
        (regRdData_r & ~`TKS_SC_IMPL_MASK) == 8'h00) else $error("scan control spare bits set");
    range_wr_a: assert property (regWrite && regAddr == `TKS_OFF_OSC_SEL |=>
        {6'h00, oscRange_r} == ($past(regWrData) & 8'h03)) else $error("osc range not written");
    mod_a_wr_a: assert property (regWrite && regAddr == `TKS_OFF_MOD_CTRL_A |=> modCtrlA_r == $past(regWrData))
        else $error("module control a not written");
    stop_wr_a: assert property (regWrite && regAddr == `TKS_OFF_SCAN_CTRL && !regWrData[`TKS_SC_START] |=>
        ##1 !keyOscRun_r && !refOscRun_r) else $error("oscillators run after stop");
    win_min_a: assert property ($rose(keyOscRun_r) |=> keyOscRun_r [*8])
        else $error("window shorter than minimum");
    cover property ($rose(keyOscRun_r));
    cover property ($fell(keyOscRun_r));
    cover property (regRead && regAddr == `TKS_OFF_IRQ_STAT);
endmodule : tks_scan_checker
bind tks_scan_top tks_scan_checker u_tks_scan_checker (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData_r(regRdData_r),
    .keyOscRun_r(keyOscRun_r), .refOscRun_r(refOscRun_r), .oscRange_r(oscRange_r), .modCtrlA_r(modCtrlA_r));

// ### test/tb_top.sv
// Self-checking bench of the touch key scan block
`include "tks_consts.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   ref_clk, reset, regWrite, regRead, irq_r, keyOscRun_r, refOscRun_r, keyOsc, refOsc;
    logic [`TKS_ADDR_W-1:0] regAddr;
    logic [7:0]             regWrData, regRdData_r, modCtrlA_r;
    logic [1:0]             oscRange_r;
    logic [3:0]             touchPinSel_r;
    logic [9:0]             refCap_r;
    logic [15:0]            k1, k2;
    int                     c1, c2;
    int                     mismatches = 0;
    int                     tests_run = 0;
    tks_scan_top u_tks_scan_top (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData_r(regRdData_r), .irq_r(irq_r), .keyOscIn(keyOsc),
        .refOscIn(refOsc), .keyOscRun_r(keyOscRun_r), .refOscRun_r(refOscRun_r), .oscRange_r(oscRange_r),
        .touchPinSel_r(touchPinSel_r), .modCtrlA_r(modCtrlA_r), .refCap_r(refCap_r));
    tks_osc_model u_tks_osc_model (.keyRun(keyOscRun_r), .refRun(refOscRun_r), .keyOsc(keyOsc), .refOsc(refOsc));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdData_r;
        @(posedge ref_clk);
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK($sformatf("reg%0h", a), e, d)
    endtask : rdchk
    task automatic irqchk(input logic e);
        #1 `CHK("irq", e, irq_r)
        @(posedge ref_clk);
    endtask : irqchk
    task automatic t_reset();
        `CHK("oscRange", 2'h3, oscRange_r)
        rdchk(`TKS_OFF_OSC_SEL, 8'h03);
        rdchk(`TKS_OFF_SCAN_CTRL, 8'h00);
        rdchk(`TKS_OFF_CAL_LO, 8'h00);
        rdchk(`TKS_OFF_FREQ_HI, 8'h00);
        rdchk(4'hF, 8'h00);
    endtask : t_reset
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            wr(`TKS_OFF_OSC_SEL, 8'hFC | 8'(i));
            `CHK("oscRange", 2'(i), oscRange_r)
            rdchk(`TKS_OFF_OSC_SEL, 8'(i));
        end
        wr(`TKS_OFF_REFCAP_HI, 8'hFF);
        rdchk(`TKS_OFF_REFCAP_HI, 8'h03);
        `CHK("refCapHi", 2'h3, refCap_r[9:8])
        wr(`TKS_OFF_SCAN_CTRL, 8'h84);
        rdchk(`TKS_OFF_SCAN_CTRL, 8'h00);
        wr(`TKS_OFF_MOD_CTRL_A, 8'hA5);
        `CHK("modCtrlA", 8'hA5, modCtrlA_r)
        wr(`TKS_OFF_MOD_CTRL_B, 8'hF5);
        rdchk(`TKS_OFF_MOD_CTRL_B, 8'hB5);
        `CHK("touchPinSel", 4'h5, touchPinSel_r)
        wr(4'hE, 8'hFF);
        rdchk(4'hE, 8'h00);
    endtask : t_regs
    task automatic scan(input logic [7:0] pre, input logic [1:0] cs, output int cyc, output logic [15:0] cal);
        logic [7:0] lo, hi, f;
        wr(`TKS_OFF_SCAN_CTRL, 8'h00);
        wr(`TKS_OFF_PRELOAD, pre);
        rd(`TKS_OFF_IRQ_STAT, lo);
        wr(`TKS_OFF_SCAN_CTRL, 8'h20 | 8'(cs));
        #1 `CHK("keyOscRun", 1'b1, keyOscRun_r)
        `CHK("refOscRun", 1'b1, refOscRun_r)
        cyc = 0;
        while (irq_r !== 1'b1 && cyc < 5000) begin
            @(posedge ref_clk);
            #1 cyc++;
        end
        @(posedge ref_clk);
        rdchk(`TKS_OFF_SCAN_CTRL, 8'h60 | 8'(cs));
        `CHK("keyOscRun", 1'b0, keyOscRun_r)
        `CHK("refOscRun", 1'b0, refOscRun_r)
        rd(`TKS_OFF_CAL_LO, lo);
        rd(`TKS_OFF_CAL_HI, hi);
        rd(`TKS_OFF_FREQ_LO, f);
        `CHK("freqNonZero", 1'b1, f != 8'h00)
        repeat (40) @(posedge ref_clk);
        rdchk(`TKS_OFF_CAL_LO, lo);
        rdchk(`TKS_OFF_FREQ_LO, f);
        cal = {hi, lo};
    endtask : scan
    task automatic t_flags();
        logic [7:0] d;
        wr(`TKS_OFF_IRQ_MASK, 8'h00);
        irqchk(1'b0);
        wr(`TKS_OFF_IRQ_MASK, 8'h01);
        irqchk(1'b1);
        rd(`TKS_OFF_IRQ_STAT, d);
        `CHK("irqStat", 8'h01, d)
        irqchk(1'b0);
        wr(`TKS_OFF_SCAN_CTRL, 8'h00);
        rdchk(`TKS_OFF_CAL_HI, 8'h00);
        rdchk(`TKS_OFF_FREQ_LO, 8'h00);
        wr(`TKS_OFF_SCAN_CTRL, 8'h40);
        rdchk(`TKS_OFF_SCAN_CTRL, 8'h00);
        rdchk(`TKS_OFF_IRQ_STAT, 8'h00);
        irqchk(1'b0);
    endtask : t_flags
    task automatic final_report();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        #300000;
        mismatches++;
        final_report();
    end
    initial begin
        reset = 1'b1;
        regAddr = '0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_regs();
        wr(`TKS_OFF_IRQ_MASK, 8'h01);
        scan(8'hFE, 2'h0, c1, k1);
        scan(8'hFC, 2'h3, c2, k2);
        `CHK("winDelta", 1'b1, (c2 - c1 >= 253) && (c2 - c1 <= 259))
        `CHK("calRatio", 1'b1, (int'(k1) + 12 >= 4 * int'(k2)) && (int'(k1) <= 4 * int'(k2) + 12))
        wr(`TKS_OFF_MOD_CTRL_B, 8'h35);
        scan(8'hFF, 2'h0, c1, k1);
        `CHK("refWin", 1'b1, (c1 >= 120) && (c1 <= 170))
        t_flags();
        final_report();
    end
endmodule : tb_top
